// File: sehl_pkg.sv
// package for the secondary error header log: offsets, field layout, types
// assumes a 32-bit configuration read port and a 40 MHz system clock
package sehl_pkg;

    // byte offsets in extended configuration space
    localparam logic [11:0] SEHL_OFS_WORD0 = 12'h13c;
    localparam logic [11:0] SEHL_OFS_WORD1 = 12'h140;
    localparam logic [11:0] SEHL_OFS_WORD2 = 12'h144;
    localparam logic [11:0] SEHL_OFS_WORD3 = 12'h148;

    // field positions inside the 128-bit log
    localparam int SEHL_ADDR_HI_MSB = 127;
    localparam int SEHL_ADDR_HI_LSB = 96;
    localparam int SEHL_ADDR_LO_MSB = 95;
    localparam int SEHL_ADDR_LO_LSB = 64;
    localparam int SEHL_RSVD_MSB    = 63;
    localparam int SEHL_RSVD_LSB    = 44;
    localparam int SEHL_UCMD_MSB    = 43;
    localparam int SEHL_UCMD_LSB    = 40;
    localparam int SEHL_LCMD_MSB    = 39;
    localparam int SEHL_LCMD_LSB    = 36;
    localparam int SEHL_ATTR_MSB    = 35;

    // reset values
    localparam logic [31:0] SEHL_WORD_RST = 32'h0000_0000;
    localparam logic [3:0]  SEHL_CMD_RST  = 4'h0;

    // one captured bus cycle header
    typedef struct packed {
        logic [31:0] addr_hi;
        logic [31:0] addr_lo;
        logic [3:0]  cmd_hi;
        logic [3:0]  cmd_lo;
    } sehl_hdr_t;

    // configuration read request and answer
    typedef struct packed {
        logic        rd;
        logic [11:0] addr;
    } sehl_cfg_req_t;

    typedef struct packed {
        logic        hit;
        logic [31:0] data;
    } sehl_cfg_rsp_t;

    localparam sehl_hdr_t SEHL_HDR_RST = '{SEHL_WORD_RST, SEHL_WORD_RST,
                                           SEHL_CMD_RST, SEHL_CMD_RST};

endpackage

// File: sehl_rst_sync.sv
// fundamental reset combiner with three-stage pin synchroniser
// assumes both reset pins are asynchronous and active low
`timescale 1ns/1ps
module sehl_rst_sync
    import sehl_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic link_reset_n_i,
    input  wire logic global_reset_n_i,
    output logic      fundamental_reset_n_o
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       fund_n_q;
    logic       fund_n_d;

    // either pin low asserts the combined reset
    always_comb
    begin
        sync_d   = {sync_q[1:0], link_reset_n_i & global_reset_n_i}; // RQ11
        fund_n_d = fund_n_q;
        // change counts once stages two and three agree
        if (sync_q[2] == sync_q[1])
        begin
            fund_n_d = sync_q[2];
        end
    end

    // no async reset here: pins only arrive through the chain
    always_ff @(posedge clk_sys_i)
    begin
        sync_q   <= sync_d;
        fund_n_q <= fund_n_d;
    end

    assign fundamental_reset_n_o = fund_n_q;
endmodule

// File: sehl_word_mux.sv
// selects one 32-bit word of the log by configuration offset
// assumes the caller registers the result
`timescale 1ns/1ps
module sehl_word_mux
    import sehl_pkg::*;
(
    input  wire logic [127:0] log_i,
    input  wire logic [11:0]  addr_i,
    output sehl_cfg_rsp_t     rsp_o
);
    // address decode, low offset carries bits 31:0
    always_comb
    begin
        rsp_o = '{1'b0, SEHL_WORD_RST};
        if (addr_i == SEHL_OFS_WORD0)
        begin
            rsp_o = '{1'b1, log_i[31:0]};  // RQ2
        end
        else if (addr_i == SEHL_OFS_WORD1)
        begin
            rsp_o = '{1'b1, log_i[63:32]};
        end
        else if (addr_i == SEHL_OFS_WORD2)
        begin
            rsp_o = '{1'b1, log_i[95:64]};
        end
        else if (addr_i == SEHL_OFS_WORD3)
        begin
            rsp_o = '{1'b1, log_i[127:96]};
        end
    end
endmodule

// File: sehl_top.sv
// secondary error header log: captures the pci address phases of the
// newest secondary error and returns them as four read-only words.
// assumes the error detector pulses err_set_i in the cycle it sets its
// status bit, and that address phase strobes come from logic on clk_sys_i.
`timescale 1ns/1ps
// Operation
// RQ1 - each detected error overwrites the log with its cycle's address and command
// RQ2 - log read as four words, lowest offset gives bits 31:0
// RQ3 - first address phase into 95:64, second into 127:96
// RQ4 - single address phase writes zero into bits 127:96
// RQ5 - bits 63:44 always read zero
// RQ6 - dual address cycle second phase command into 43:40
// RQ7 - first phase command into 39:36
// RQ8 - bits 35:0 have no function and read zero
// RQ9 - all words reset to zero, writes ignored
// RQ10 - only fundamental reset clears captured fields
// RQ11 - fundamental reset asserted when link or global reset asserted
// RQ12 - log loaded in the same cycle the status bit is set
module sehl_top
    import sehl_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    input  wire logic        link_reset_n_i,
    input  wire logic        global_reset_n_i,
    input  wire logic        addr_phase1_i,
    input  wire logic        addr_phase2_i,
    input  wire logic [31:0] pci_ad_i,
    input  wire logic [3:0]  pci_cbe_i,
    input  wire logic        err_set_i,
    input  wire logic        cfg_rd_i,
    input  wire logic        cfg_wr_i,
    input  wire logic [11:0] cfg_addr_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic [31:0]      cfg_rdata_o,
    output logic             cfg_hit_o,
    output logic             fundamental_reset_n_o
);
    logic          fund_n;
    sehl_hdr_t     cur_q;
    sehl_hdr_t     cur_d;
    sehl_hdr_t     log_q;
    sehl_hdr_t     log_d;
    logic [127:0]  log_flat;
    sehl_cfg_rsp_t rsp;
    logic [31:0]   rdata_q;
    logic [31:0]   rdata_d;
    logic          hit_q;
    logic          hit_d;
    logic          fund_q;
    logic          unused_wr;

    sehl_rst_sync u_rst
    (
        .clk_sys_i             (clk_sys_i),
        .link_reset_n_i        (link_reset_n_i),
        .global_reset_n_i      (global_reset_n_i),
        .fundamental_reset_n_o (fund_n)
    );

    // writes are accepted and dropped: the log is read only
    assign unused_wr = cfg_wr_i & (|cfg_wdata_i); // RQ9

    // track the header of the cycle in flight on the secondary bus
    always_comb
    begin
        cur_d = cur_q;
        if (addr_phase1_i)
        begin
            cur_d.addr_lo = pci_ad_i;      // RQ3
            cur_d.cmd_lo  = pci_cbe_i;     // RQ7
            cur_d.addr_hi = SEHL_WORD_RST; // RQ4
            cur_d.cmd_hi  = SEHL_CMD_RST;
        end
        else if (addr_phase2_i)
        begin
            cur_d.addr_hi = pci_ad_i;      // RQ3
            cur_d.cmd_hi  = pci_cbe_i;     // RQ6
        end
    end

    // newest error wins; capture in the status-set cycle
    always_comb
    begin
        log_d = log_q;
        if (err_set_i)
        begin
            log_d = cur_q; // RQ1 RQ12
        end
    end

    // only the fundamental reset clears the log, srst_i leaves it
    always_ff @(posedge clk_sys_i)
    begin
        if (!fund_n)
        begin
            cur_q <= SEHL_HDR_RST; // RQ10
            log_q <= SEHL_HDR_RST; // RQ9
        end
        else
        begin
            cur_q <= cur_d;
            log_q <= log_d;
        end
    end

    // reserved and attribute bits are wired to zero
    assign log_flat = {log_q.addr_hi, log_q.addr_lo,
                       20'h0_0000,                 // RQ5
                       log_q.cmd_hi, log_q.cmd_lo,
                       36'h0_0000_0000};           // RQ8

    sehl_word_mux u_mux
    (
        .log_i  (log_flat),
        .addr_i (cfg_addr_i),
        .rsp_o  (rsp)
    );

    // registered read answer, one cycle after the request
    always_comb
    begin
        rdata_d = SEHL_WORD_RST;
        hit_d   = 1'b0;
        if (cfg_rd_i)
        begin
            rdata_d = rsp.data; // RQ2
            hit_d   = rsp.hit;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            rdata_q <= SEHL_WORD_RST;
            hit_q   <= 1'b0;
            fund_q  <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            hit_q   <= hit_d;
            fund_q  <= fund_n;
        end
    end

    assign cfg_rdata_o           = rdata_q;
    assign cfg_hit_o             = hit_q;
    assign fundamental_reset_n_o = fund_q;
endmodule

// File: sehl_asserts.sv
// checker for the header log read port and reset combiner
// assumes it is bound onto sehl_top, one clock domain
`timescale 1ns/1ps
module sehl_chk
    import sehl_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        srst_i,
    input wire logic        link_reset_n_i,
    input wire logic        global_reset_n_i,
    input wire logic        cfg_rd_i,
    input wire logic [11:0] cfg_addr_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic        cfg_hit_o,
    input wire logic        fundamental_reset_n_o
);
    logic m;
    logic w1;
    // decode of the four log offsets
    assign m = cfg_addr_i inside {SEHL_OFS_WORD0, SEHL_OFS_WORD1, SEHL_OFS_WORD2, SEHL_OFS_WORD3};
    assign w1 = cfg_rd_i && cfg_addr_i == SEHL_OFS_WORD1;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    hit_on_map_a: assert property (cfg_rd_i && m |=> cfg_hit_o)
        else $error("no hit");
    quiet_else_a: assert property (!(cfg_rd_i && m) |=> !cfg_hit_o && cfg_rdata_o == '0)
        else $error("stray answer");
    low_word_a: assert property (cfg_rd_i && cfg_addr_i == SEHL_OFS_WORD0 |=> cfg_rdata_o == '0)
        else $error("word0 not zero");
    rsvd_zero_a: assert property (w1 |=> cfg_rdata_o[31:12] == 20'h0)
        else $error("reserved bits set");
    attr_zero_a: assert property (w1 |=> cfg_rdata_o[3:0] == 4'h0)
        else $error("attribute bits set");
    link_fund_a: assert property (!link_reset_n_i [*6] |=> !fundamental_reset_n_o)
        else $error("link reset lost");
    glob_fund_a: assert property (!global_reset_n_i [*6] |=> !fundamental_reset_n_o)
        else $error("global reset lost");
    fund_clear_a: assert property (!fundamental_reset_n_o [*2] ##0 cfg_rd_i
        |=> cfg_rdata_o == '0) else $error("log kept in reset");
endmodule
bind sehl_top sehl_chk chk_inst(.clk_sys_i, .srst_i, .link_reset_n_i, .global_reset_n_i,
    .cfg_rd_i, .cfg_addr_i, .cfg_rdata_o, .cfg_hit_o, .fundamental_reset_n_o);

// File: sehl_pci_agent.sv
// pci master model: address phases plus error pulse
// assumes callers step on the falling edge of clk_sys_i
`timescale 1ns/1ps
module sehl_pci_agent
    import sehl_pkg::*;
(
    input  wire logic   clk_sys_i,
    output logic        ph1_o,
    output logic        ph2_o,
    output logic [31:0] ad_o,
    output logic [3:0]  cbe_o,
    output logic        err_o
);
    initial {ph1_o, ph2_o, err_o, ad_o, cbe_o} = '0;
    // released lines invert, so a stale sample never matches by luck
    task xfer(input sehl_hdr_t h, input logic dac, input logic err);
        {ph1_o, ad_o, cbe_o} = {1'b1, h.addr_lo, h.cmd_lo};
        @(negedge clk_sys_i);
        if (dac)
        begin
            {ph1_o, ph2_o, ad_o, cbe_o} = {2'b01, h.addr_hi, h.cmd_hi};
            @(negedge clk_sys_i);
        end
        {ph1_o, ph2_o, err_o, ad_o, cbe_o} = {2'b00, err, ~ad_o, ~cbe_o};
        @(negedge clk_sys_i);
        err_o = 1'b0;
    endtask
endmodule

// File: sehl_top_test.sv
// self-checking bench for sehl_top with a pci master model
// assumes the checker file is compiled alongside
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin samples_checked++; if ((ac) !== (ex)) begin err_count++; \
    $display("BAD %s exp %h got %h", nm, ex, ac); end end
module sehl_top_test
    import sehl_pkg::*;
;
    logic clk_sys_i, srst_i, link_reset_n_i, global_reset_n_i, cfg_rd_i, cfg_wr_i;
    logic addr_phase1_i, addr_phase2_i, err_set_i, cfg_hit_o, fundamental_reset_n_o;
    logic [11:0] cfg_addr_i;
    logic [31:0] cfg_wdata_i, cfg_rdata_o, pci_ad_i;
    logic [3:0] pci_cbe_i;
    int err_count, samples_checked;
    sehl_hdr_t hd, hs;
    sehl_top sehl_top_inst(.clk_sys_i, .srst_i, .link_reset_n_i, .global_reset_n_i,
        .addr_phase1_i, .addr_phase2_i, .pci_ad_i, .pci_cbe_i, .err_set_i, .cfg_rd_i,
        .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_hit_o, .fundamental_reset_n_o);
    sehl_pci_agent sehl_pci_agent_inst(.clk_sys_i, .ph1_o(addr_phase1_i),
        .ph2_o(addr_phase2_i), .ad_o(pci_ad_i), .cbe_o(pci_cbe_i), .err_o(err_set_i));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // reads stay raised so groups run back to back; caller lowers
    task rd(input logic [11:0] a, input logic [31:0] d, input logic h);
        {cfg_rd_i, cfg_addr_i} = {1'b1, a};
        @(negedge clk_sys_i);
        `CHK("rdata", d, cfg_rdata_o)
        `CHK("hit", h, cfg_hit_o)
    endtask
    task chk_log(input sehl_hdr_t h);
        rd(SEHL_OFS_WORD0, 32'h0, 1'b1);
        rd(SEHL_OFS_WORD1, {20'h0, h.cmd_hi, h.cmd_lo, 4'h0}, 1'b1);
        rd(SEHL_OFS_WORD2, h.addr_lo, 1'b1);
        rd(SEHL_OFS_WORD3, h.addr_hi, 1'b1);
        cfg_rd_i = 1'b0;
    endtask
    task t_dac;
        sehl_pci_agent_inst.xfer(hd, 1'b1, 1'b1);
        chk_log(hd);
        $display("test dual address done");
    endtask
    // a single phase overwrites the dual record and zeroes the upper address word, bits 127:96
    task t_single;
        sehl_pci_agent_inst.xfer(hs, 1'b0, 1'b1);
        chk_log(hs);
        $display("test single address done");
    endtask
    task t_keep;
        sehl_pci_agent_inst.xfer(hd, 1'b1, 1'b0);
        {cfg_wr_i, cfg_wdata_i} = {1'b1, 32'hffff_ffff};
        for (int i = 0; i < 4; i++)
        begin
            cfg_addr_i = SEHL_OFS_WORD0 + 12'(i * 4);
            @(negedge clk_sys_i);
        end
        {cfg_wr_i, srst_i} = 2'b01;
        repeat (2) @(negedge clk_sys_i);
        srst_i = 1'b0;
        chk_log(hs);
        rd(12'h138, 32'h0, 1'b0);
        rd(12'h14c, 32'h0, 1'b0);
        cfg_rd_i = 1'b0;
        $display("test write and light reset done");
    endtask
    task t_pin(input logic g);
        sehl_pci_agent_inst.xfer(hd, 1'b1, 1'b1);
        {link_reset_n_i, global_reset_n_i} = {g, ~g};
        repeat (6) @(negedge clk_sys_i);
        `CHK("fund_rst", 1'b0, fundamental_reset_n_o)
        // a read while the pin still holds reset must already see a cleared log
        rd(SEHL_OFS_WORD2, 32'h0, 1'b1);
        {cfg_rd_i, link_reset_n_i, global_reset_n_i} = 3'b011;
        repeat (8) @(negedge clk_sys_i);
        `CHK("fund_rst", 1'b1, fundamental_reset_n_o)
        chk_log(SEHL_HDR_RST);
        $display("test pin reset done");
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        {srst_i, link_reset_n_i, global_reset_n_i, cfg_rd_i, cfg_wr_i} = 5'b10000;
        {cfg_addr_i, cfg_wdata_i, err_count, samples_checked} = '0;
        hd = '{32'h8000_0004, 32'h1234_5678, 4'h7, 4'hd};
        hs = '{32'h0, 32'hcafe_0010, 4'h0, 4'h6};
        repeat (6) @(negedge clk_sys_i);
        {srst_i, link_reset_n_i, global_reset_n_i} = 3'b011;
        repeat (8) @(negedge clk_sys_i);
        chk_log(SEHL_HDR_RST);
        t_dac();
        t_single();
        t_keep();
        t_pin(1'b1);
        t_pin(1'b0);
        give_verdict();
    end
    // the run needs about 90 cycles
    initial
    begin
        #(25 * 3000);
        err_count++;
        give_verdict();
    end
endmodule
